// ---- src/pci_link_regs.svh ----
// Purpose: Offsets, field positions, reset values and codes of the link
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef PCI_LINK_REGS_SVH
`define PCI_LINK_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (low address byte) and target base (upper address bytes)
// ----------------------------------------------------------------------
`define CMD_STAT_OFS     8'h04
`define INT_CTRL_OFS     8'h38
`define TGT_BASE         24'h000100

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CMD_PERR_EN_BIT  6
`define CMD_SERR_EN_BIT  8
`define STS_SHIFT        16
`define STS_SERR_BIT     14
`define STS_PERR_BIT     15
`define INT_SRC_BIT      0
`define INT_ADDON_BIT    1
`define INT_EN_BIT       8

// ----------------------------------------------------------------------
// Reset values and bus commands
// ----------------------------------------------------------------------
`define CMD_RESET        16'h0000
`define CMD_MEM_RD       4'h6
`define CMD_MEM_WR       4'h7
`define BE_ALL_N         4'h0

`endif

// ---- src/pci_link_pkg.sv ----
// Purpose: Shared types and parity helper of both link ends
// Assumes: Nothing
// Notes:   Constants live in pci_link_regs.svh
package pci_link_pkg;

   // -------------------------------------------------------------------
   // State encodings
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      TGT_IDLE  = 3'b001,
      TGT_DATA  = 3'b010,
      TGT_RETRY = 3'b100
   } tgt_state_t;

   typedef enum logic [3:0] {
      MST_IDLE = 4'b0001,
      MST_ADDR = 4'b0010,
      MST_DATA = 4'b0100,
      MST_PAR  = 4'b1000
   } mst_state_t;

   // -------------------------------------------------------------------
   // Even parity over address/data and command/byte enables
   // -------------------------------------------------------------------
   function automatic logic even_par(logic [31:0] ad, logic [3:0] cbe);
      return ^{ad, cbe};
   endfunction

endpackage

// ---- src/pci_link_if.sv ----
// Purpose: Bus wires between bus master end and target end
// Assumes: One master, one target
// Notes:   Resolves shared and open-drain lines from enables
`timescale 1ns/1ps
interface pci_link_if;
   logic        frame_n;
   logic        irdy_n;
   logic        lock_n;
   logic [3:0]  cbe_n;
   logic [31:0] m_ad;
   logic        m_par;
   logic        m_par_oe;
   logic        trdy_n;
   logic        devsel_n;
   logic        stop_n;
   logic [31:0] t_ad;
   logic        t_ad_oe;
   logic        t_par;
   logic        t_par_oe;
   logic        inta_oe;
   logic        serr_oe;
   logic        perr_o;
   logic        perr_oe;
   logic [31:0] ad;
   logic        par;
   logic        inta_n;
   logic        serr_n;
   logic        perr_n;

   // -------------------------------------------------------------------
   // Line resolution
   // -------------------------------------------------------------------
   assign ad     = t_ad_oe ? t_ad : m_ad;
   assign par    = t_par_oe ? t_par : m_par;
   assign inta_n = ~inta_oe;
   assign serr_n = ~serr_oe;
   assign perr_n = perr_oe ? perr_o : 1'b1;

   modport target (
      input  frame_n, irdy_n, lock_n, cbe_n, ad, par,
      output trdy_n, devsel_n, stop_n, t_ad, t_ad_oe, t_par, t_par_oe,
      output inta_oe, serr_oe, perr_o, perr_oe
   );

   modport master (
      output frame_n, irdy_n, lock_n, cbe_n, m_ad, m_par, m_par_oe,
      input  ad, par, trdy_n, devsel_n, stop_n, inta_n, serr_n, perr_n
   );
endinterface

// ---- src/pci_master_end.sv ----
// Purpose: Bus master end issuing single-phase memory accesses
// Assumes: Sole master on the link; bus inputs on sys_clk
// Notes:   Owns the lock once established, drops it on request
`timescale 1ns/1ps
`include "pci_link_regs.svh"
module pci_master_end (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // Bus
   pci_link_if.master       bus,
   // Request
   input  wire logic        req,
   input  wire logic        req_write,
   input  wire logic        req_lock,
   input  wire logic        req_unlock,
   input  wire logic        req_bad_par,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_data,
   // Answer
   output logic             busy,
   output logic             done,
   output logic             retried,
   output logic             aborted,
   output logic             own_lock,
   output logic [31:0]      rd_data
);

   typedef struct packed {
      pci_link_pkg::mst_state_t st;
      logic        frame_n;
      logic        irdy_n;
      logic        lock_n;
      logic [3:0]  cbe_n;
      logic [31:0] ad;
      logic        par;
      logic        par_oe;
      logic        wr;
      logic        lk;
      logic        unlk;
      logic        bad;
      logic [31:0] data;
      logic        own;
      logic        busy;
      logic        done;
      logic        retried;
      logic        aborted;
      logic [31:0] rd_data;
   } mst_t;

   mst_t r;
   mst_t n;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      n         = r;
      n.done    = 1'b0;
      n.retried = 1'b0;
      n.aborted = 1'b0;
      unique case (r.st)
         pci_link_pkg::MST_IDLE: begin
            n.par_oe = 1'b0;
            if (req) begin
               n.st      = pci_link_pkg::MST_ADDR;
               n.busy    = 1'b1;
               n.wr      = req_write;
               n.lk      = req_lock | r.own;
               n.unlk    = req_unlock;
               n.bad     = req_bad_par;
               n.data    = req_data;
               n.frame_n = 1'b0;
               n.lock_n  = 1'b1;                       // see [RULE5]
               n.ad      = req_addr;
               n.cbe_n   = req_write ? `CMD_MEM_WR : `CMD_MEM_RD;
            end
         end
         pci_link_pkg::MST_ADDR: begin
            n.st      = pci_link_pkg::MST_DATA;
            n.frame_n = 1'b1;
            n.irdy_n  = 1'b0;
            n.lock_n  = ~(r.lk & ~r.unlk);
            n.par     = pci_link_pkg::even_par(r.ad, r.cbe_n) ^ r.bad;
            n.par_oe  = 1'b1;                          // see [RULE13]
            n.ad      = r.wr ? r.data : 32'h0000_0000;
            n.cbe_n   = `BE_ALL_N;
         end
         pci_link_pkg::MST_DATA: begin
            n.par_oe = 1'b0;
            if (~bus.trdy_n | ~bus.stop_n) begin
               n.st      = pci_link_pkg::MST_PAR;
               n.irdy_n  = 1'b1;
               n.busy    = 1'b0;
               n.par     = pci_link_pkg::even_par(r.ad, r.cbe_n) ^ r.bad;
               n.par_oe  = r.wr;
               if (~bus.trdy_n) begin
                  n.done    = 1'b1;                    // see [RULE1]
                  n.rd_data = bus.ad;
                  n.own     = r.lk & ~r.unlk;
               end else if (~bus.devsel_n) begin
                  n.retried = 1'b1;                    // see [RULE2]
               end else begin
                  n.aborted = 1'b1;                    // see [RULE3]
               end
               n.lock_n = ~(n.own);
            end
         end
         pci_link_pkg::MST_PAR: begin
            n.st     = pci_link_pkg::MST_IDLE;
            n.par_oe = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r         <= '0;
         r.st      <= pci_link_pkg::MST_IDLE;
         r.frame_n <= 1'b1;
         r.irdy_n  <= 1'b1;
         r.lock_n  <= 1'b1;
      end else if (ce) begin
         r <= n;
      end
   end

   assign bus.frame_n  = r.frame_n;
   assign bus.irdy_n   = r.irdy_n;
   assign bus.lock_n   = r.lock_n;
   assign bus.cbe_n    = r.cbe_n;
   assign bus.m_ad     = r.ad;
   assign bus.m_par    = r.par;
   assign bus.m_par_oe = r.par_oe;
   assign busy         = r.busy;
   assign done         = r.done;
   assign retried      = r.retried;
   assign aborted      = r.aborted;
   assign own_lock     = r.own;
   assign rd_data      = r.rd_data;

endmodule

// ---- src/pci_target_end.sv ----
// Purpose: Target end: terminations, locking, interrupt, parity errors
// Assumes: Bus inputs on sys_clk; add-on interrupt pin asynchronous
// Notes:   Single data phase per access, ended by disconnect, or by retry for non-owners while locked
//
// Operation
// [RULE1] Disconnect: device select, stop, target ready
// [RULE2] Retry: select and stop, no target ready
// [RULE3] Abort: stop only, no select, no ready
// [RULE4] Selected with lock free, then taken: locked
// [RULE5] Owner starts each access with lock free
// [RULE6] Unlock after final transfer with lock free
// [RULE7] Unlocked target ignores lock held at start
// [RULE8] Locked target retries accesses by non-owners
// [RULE9] Interrupt line is open-drain, clock-free timing; here inta_oe is a register on sys_clk
// [RULE10] Interrupt held until software clears source
// [RULE11] Interrupt held while add-on input low
// [RULE12] Add-on releases input; software clears before exit
// [RULE13] Parity even over lines, one clock later
// [RULE14] Address parity reported only when enabled
// [RULE15] System error low one clock after parity
// [RULE16] System-error status sticky until cleared or reset
// [RULE17] Parity error pin only as write target, enabled
// [RULE18] Data parity status set regardless of enable
// [RULE19] Parity error two clocks after transfer, one-clock
// [RULE20] Data parity checked only on actual transfer
// [RULE21] Data errors on parity pin, address on system
// [RULE22] Never terminate with target abort
`timescale 1ns/1ps
`include "pci_link_regs.svh"
module pci_target_end (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic ce,
   // Bus
   pci_link_if.target bus,
   // Add-on side
   input  wire logic irq_event,
   input  wire logic add_on_interrupt_in_n,
   output logic      locked,
   output logic      int_pending
);

   typedef struct packed {
      pci_link_pkg::tgt_state_t st;
      logic        frame_q;
      logic [7:0]  ofs;
      logic        wr;
      logic        lock_pend;
      logic        locked;
      logic [15:0] pci_command_reg;
      logic        serr_sts;
      logic        perr_sts;
      logic        int_src;
      logic        int_en;
      logic        addr_chk;
      logic        addr_par;
      logic        serr_oe;
      logic        dat_chk;
      logic        dat_par;
      logic        perr_flag;
      logic        perr_o;
      logic        perr_oe;
      logic        trdy_n;
      logic        devsel_n;
      logic        stop_n;
      logic [31:0] ad;
      logic        ad_oe;
      logic        par;
      logic        par_oe;
      logic        inta_oe;
      logic [1:0]  addon_sync;
   } tgt_t;

   tgt_t r;
   tgt_t n;

   // ----------------------------------------------------------------------
   // Read data of a register
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rd_word(tgt_t s, logic [7:0] ofs);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (ofs == `CMD_STAT_OFS) begin
         w[15:0] = s.pci_command_reg;
         w[`STS_SHIFT + `STS_SERR_BIT] = s.serr_sts;
         w[`STS_SHIFT + `STS_PERR_BIT] = s.perr_sts;
      end else if (ofs == `INT_CTRL_OFS) begin
         w[`INT_SRC_BIT]   = s.int_src;
         w[`INT_ADDON_BIT] = ~s.addon_sync[1];
         w[`INT_EN_BIT]    = s.int_en;
      end
      return w;
   endfunction

   logic start;
   logic hit;
   logic xfer;
   logic wr_cmd;
   logic wr_int;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      n      = r;
      start  = ~bus.frame_n & r.frame_q;
      hit    = (bus.ad[31:8] == `TGT_BASE) &
               ((bus.cbe_n == `CMD_MEM_RD) | (bus.cbe_n == `CMD_MEM_WR));
      xfer   = r.st[1] & ~bus.irdy_n & ~r.trdy_n;     // see [RULE20]
      wr_cmd = xfer & r.wr & (r.ofs == `CMD_STAT_OFS);
      wr_int = xfer & r.wr & (r.ofs == `INT_CTRL_OFS);
      n.frame_q    = bus.frame_n;
      n.addon_sync = {r.addon_sync[0], add_on_interrupt_in_n};

      // Address parity, any command seen on the bus
      n.addr_chk = start;
      if (start) begin
         n.addr_par = pci_link_pkg::even_par(bus.ad, bus.cbe_n);
      end
      n.serr_oe = r.addr_chk & (bus.par != r.addr_par) &
                  r.pci_command_reg[`CMD_SERR_EN_BIT];  // see [RULE14]
      // see [RULE15] [RULE21]

      // Data parity pipeline
      n.dat_chk   = xfer & r.wr;
      if (xfer) begin
         n.dat_par = pci_link_pkg::even_par(bus.ad, bus.cbe_n);
      end
      n.perr_flag = r.dat_chk & (bus.par != r.dat_par);
      // Pin follows the compare directly: two clocks after transfer
      n.perr_o    = ~(n.perr_flag &
                      r.pci_command_reg[`CMD_PERR_EN_BIT]); // see [RULE19]
      n.perr_oe   = (r.st[1] & r.wr) | r.dat_chk | r.perr_flag;
      // see [RULE17] [RULE21]

      // Read parity follows the data by one clock
      n.par_oe = xfer & ~r.wr;                        // see [RULE13]
      n.par    = pci_link_pkg::even_par(r.ad, bus.cbe_n);

      // Lock acquisition in the clock after the address
      if (r.lock_pend & ~bus.lock_n) begin
         n.locked = 1'b1;                             // see [RULE4]
      end
      n.lock_pend = 1'b0;

      unique case (r.st)
         pci_link_pkg::TGT_IDLE: begin
            if (start & hit) begin
               n.ofs      = bus.ad[7:0];
               // Read word on the lines before the first transfer
               n.ad       = rd_word(r, bus.ad[7:0]);
               n.wr       = (bus.cbe_n == `CMD_MEM_WR);
               n.devsel_n = 1'b0;                     // see [RULE22]
               n.stop_n   = 1'b0;
               if (r.locked & ~bus.lock_n) begin
                  n.st = pci_link_pkg::TGT_RETRY;     // see [RULE8] [RULE2]
               end else begin
                  n.st        = pci_link_pkg::TGT_DATA;
                  n.trdy_n    = 1'b0;                 // see [RULE1]
                  n.lock_pend = ~r.locked & bus.lock_n; // see [RULE7]
                  n.ad_oe     = (bus.cbe_n == `CMD_MEM_RD);
               end
            end
         end
         pci_link_pkg::TGT_DATA: begin
            n.ad = rd_word(r, r.ofs);
            if (xfer) begin
               n.st       = pci_link_pkg::TGT_IDLE;
               n.trdy_n   = 1'b1;
               n.devsel_n = 1'b1;
               n.stop_n   = 1'b1;
               n.ad_oe    = 1'b0;
               if (r.wr & (r.ofs == `CMD_STAT_OFS)) begin
                  n.pci_command_reg = bus.ad[15:0];
               end
               if (r.wr & (r.ofs == `INT_CTRL_OFS)) begin
                  n.int_en = bus.ad[`INT_EN_BIT];
               end
               if (r.locked & bus.lock_n) begin
                  n.locked = 1'b0;                    // see [RULE6]
               end
            end
         end
         pci_link_pkg::TGT_RETRY: begin
            if (~bus.irdy_n) begin
               n.st       = pci_link_pkg::TGT_IDLE;
               n.devsel_n = 1'b1;
               n.stop_n   = 1'b1;
            end
         end
      endcase

      // Sticky status: a set in the clearing clock wins
      n.serr_sts = (r.serr_sts &
                    ~(wr_cmd & bus.ad[`STS_SHIFT + `STS_SERR_BIT])) |
                   n.serr_oe;                         // see [RULE16]
      n.perr_sts = (r.perr_sts &
                    ~(wr_cmd & bus.ad[`STS_SHIFT + `STS_PERR_BIT])) |
                   n.perr_flag;                       // see [RULE18]
      n.int_src  = (r.int_src & ~(wr_int & bus.ad[`INT_SRC_BIT])) |
                   irq_event;                         // see [RULE10]
      n.inta_oe  = (n.int_src & n.int_en) |
                   ~r.addon_sync[1];                  // see [RULE9] [RULE11]
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         r                 <= '0;
         r.st              <= pci_link_pkg::TGT_IDLE;
         r.frame_q         <= 1'b1;
         r.pci_command_reg <= `CMD_RESET;
         r.perr_o          <= 1'b1;
         r.trdy_n          <= 1'b1;
         r.devsel_n        <= 1'b1;
         r.stop_n          <= 1'b1;
         r.addon_sync      <= 2'b11;
      end else if (ce) begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign bus.trdy_n   = r.trdy_n;
   assign bus.devsel_n = r.devsel_n;
   assign bus.stop_n   = r.stop_n;
   assign bus.t_ad     = r.ad;
   assign bus.t_ad_oe  = r.ad_oe;
   assign bus.t_par    = r.par;
   assign bus.t_par_oe = r.par_oe;
   assign bus.inta_oe  = r.inta_oe;
   assign bus.serr_oe  = r.serr_oe;
   assign bus.perr_o   = r.perr_o;
   assign bus.perr_oe  = r.perr_oe;
   assign locked       = r.locked;
   assign int_pending  = r.inta_oe;

endmodule

// ---- tb/pci_link_chk.sv ----
// Purpose: Concurrent checks on the link between both ends
// Assumes: One clock domain, reset asynchronous active high
// Notes:   Instantiated beside the link interface in tb_top
`timescale 1ns/1ps
`include "pci_link_regs.svh"
module pci_link_chk (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // Link
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic        lock_n,
   input wire logic [3:0]  cbe_n,
   input wire logic [31:0] ad,
   input wire logic        par,
   input wire logic        trdy_n,
   input wire logic        devsel_n,
   input wire logic        stop_n,
   input wire logic        serr_oe,
   input wire logic        perr_n
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_start;
      !frame_n && $past(frame_n);
   endsequence
   sequence s_hit;
      s_start ##0 (ad[31:8] == `TGT_BASE && cbe_n[3:1] == 3'b011);
   endsequence
   sequence s_xfer;
      !irdy_n && !trdy_n;
   endsequence

   property p_disc;
      s_hit ##0 lock_n |=> !devsel_n && !stop_n && !trdy_n;
   endproperty
   a_disc: assert property (p_disc)
      else $error("no disconnect answer");
   property p_xfer_stop;
      s_xfer |-> !devsel_n && !stop_n;
   endproperty
   a_xfer_stop: assert property (p_xfer_stop)
      else $error("bad end");
   property p_no_abort;
      !stop_n |-> !devsel_n;
   endproperty
   a_no_abort: assert property (p_no_abort)
      else $error("abort");
   property p_lock_free;
      s_start |-> lock_n;
   endproperty
   a_lock_free: assert property (p_lock_free)
      else $error("lock held");
   property p_serr_one;
      serr_oe |=> !serr_oe;
   endproperty
   a_serr_one: assert property (p_serr_one)
      else $error("serr long");
   property p_serr_cause;
      serr_oe |-> $past(frame_n, 3) && !$past(frame_n, 2)
         && $past(par) != ^{$past(ad, 2), $past(cbe_n, 2)};
   endproperty
   a_serr_cause: assert property (p_serr_cause)
      else $error("serr");
   property p_perr_one;
      !perr_n |=> perr_n;
   endproperty
   a_perr_one: assert property (p_perr_one)
      else $error("perr long");
   property p_perr_when;
      !perr_n |-> $past(!irdy_n && !trdy_n, 2)
         && $past(cbe_n, 3) == `CMD_MEM_WR;
   endproperty
   a_perr_when: assert property (p_perr_when)
      else $error("perr");
   property p_perr_cause;
      !perr_n |-> $past(par) != ^{$past(ad, 2), $past(cbe_n, 2)};
   endproperty
   a_perr_cause: assert property (p_perr_cause)
      else $error("par");
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench joining master end and target end
// Assumes: Inputs driven at the falling clock edge
// Notes:   Parity, interrupt, lock and register traffic
`timescale 1ns/1ps
`include "pci_link_regs.svh"
module tb_top;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        req, req_write, req_lock, req_unlock, req_bad_par;
   logic        irq_event, add_on_n;
   logic [31:0] req_addr, req_data, rd_data;
   logic        busy, done, retried, aborted, own_lock, locked, int_pending;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;
   int          serr_cnt = 0;
   int          perr_cnt = 0;
   int          abort_cnt = 0;
   int          retry_cnt = 0;

   pci_link_if link ();
   pci_master_end u_pci_master_end (.sys_clk(sys_clk), .reset(reset),
      .ce(1'b1), .bus(link), .req(req), .req_write(req_write),
      .req_lock(req_lock), .req_unlock(req_unlock),
      .req_bad_par(req_bad_par), .req_addr(req_addr),
      .req_data(req_data), .busy(busy), .done(done), .retried(retried),
      .aborted(aborted), .own_lock(own_lock), .rd_data(rd_data));
   pci_target_end u_pci_target_end (.sys_clk(sys_clk), .reset(reset),
      .ce(1'b1), .bus(link), .irq_event(irq_event),
      .add_on_interrupt_in_n(add_on_n), .locked(locked),
      .int_pending(int_pending));
   pci_link_chk u_pci_link_chk (.sys_clk(sys_clk), .reset(reset),
      .frame_n(link.frame_n), .irdy_n(link.irdy_n), .lock_n(link.lock_n),
      .cbe_n(link.cbe_n), .ad(link.ad), .par(link.par),
      .trdy_n(link.trdy_n), .devsel_n(link.devsel_n),
      .stop_n(link.stop_n), .serr_oe(link.serr_oe), .perr_n(link.perr_n));

   always #10 sys_clk = ~sys_clk;

   // ------------------------------------------------------------------
   // Error-pin and abort/retry answer pulse counters and hang limit
   // ------------------------------------------------------------------
   always @(negedge sys_clk) begin
      serr_cnt += (link.serr_n === 1'b0);
      perr_cnt += (link.perr_n === 1'b0);
      abort_cnt += (aborted === 1'b1);
      retry_cnt += (retried === 1'b1);
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------------
   // Compare, access and closing tasks
   // ------------------------------------------------------------------
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic access(input logic wr, input logic [7:0] ofs,
         input logic [31:0] data, input logic lk, input logic ul,
         input logic bad);
      int n;
      n = 0;
      @(negedge sys_clk);
      req = 1'b1;
      req_write = wr;
      req_addr = {`TGT_BASE, ofs};
      req_data = data;
      req_lock = lk;
      req_unlock = ul;
      req_bad_par = bad;
      @(negedge sys_clk);
      req = 1'b0;
      while (done !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      check_bit(done, 1'b1);
      check_bit(busy, 1'b0);
      @(negedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d,
         input logic bad);
      access(1'b1, ofs, d, 1'b0, 1'b0, bad);
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
      access(1'b0, ofs, 32'h0, 1'b0, 1'b0, 1'b0);
      check_word(rd_data, exp);
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      {req, req_write, req_lock, req_unlock, req_bad_par} = 5'h00;
      {req_addr, req_data} = 64'h0;
      irq_event = 1'b0;
      add_on_n = 1'b1;
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      check_bit(link.inta_n, 1'b1);
      rd(`CMD_STAT_OFS, 32'h0000_0000);
      wr(`CMD_STAT_OFS, 32'h0000_0140, 1'b0);
      rd(`CMD_STAT_OFS, 32'h0000_0140);
      wr(`INT_CTRL_OFS, 32'h0000_0000, 1'b1);
      rd(`CMD_STAT_OFS, 32'hc000_0140);
      check_word(serr_cnt, 32'h1);
      check_word(perr_cnt, 32'h1);
      wr(`CMD_STAT_OFS, 32'hc000_0000, 1'b0);
      rd(`CMD_STAT_OFS, 32'h0000_0000);
      wr(`INT_CTRL_OFS, 32'h0000_0000, 1'b1);
      rd(`CMD_STAT_OFS, 32'h8000_0000);
      check_word(serr_cnt, 32'h1);
      check_word(perr_cnt, 32'h1);
      wr(`CMD_STAT_OFS, 32'hc000_0040, 1'b0);
      access(1'b0, `CMD_STAT_OFS, 32'h0, 1'b0, 1'b0, 1'b1);
      rd(`CMD_STAT_OFS, 32'h0000_0040);
      check_word(perr_cnt, 32'h1);
      wr(8'h10, 32'hffff_ffff, 1'b0);
      rd(8'h10, 32'h0000_0000);
      // Interrupt source, then add-on pin
      wr(`INT_CTRL_OFS, 32'h0000_0100, 1'b0);
      irq_event = 1'b1;
      @(negedge sys_clk);
      irq_event = 1'b0;
      repeat (4) @(negedge sys_clk);
      check_bit(link.inta_n, 1'b0);
      rd(`INT_CTRL_OFS, 32'h0000_0101);
      check_bit(int_pending, 1'b1);
      wr(`INT_CTRL_OFS, 32'h0000_0101, 1'b0);
      repeat (3) @(negedge sys_clk);
      check_bit(link.inta_n, 1'b1);
      add_on_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      check_bit(link.inta_n, 1'b0);
      rd(`INT_CTRL_OFS, 32'h0000_0102);
      wr(`INT_CTRL_OFS, 32'h0000_0101, 1'b0);
      check_bit(link.inta_n, 1'b0);
      add_on_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      check_bit(link.inta_n, 1'b1);
      // Lock by owner, later access, release
      access(1'b1, `INT_CTRL_OFS, 32'h0, 1'b1, 1'b0, 1'b0);
      check_bit(locked, 1'b1);
      check_bit(own_lock, 1'b1);
      rd(`CMD_STAT_OFS, 32'h0000_0040);
      check_bit(locked, 1'b1);
      access(1'b1, `INT_CTRL_OFS, 32'h0, 1'b0, 1'b1, 1'b0);
      check_bit(locked, 1'b0);
      check_word(abort_cnt, 32'h0);
      check_word(retry_cnt, 32'h0);
      end_of_test();
   end
endmodule
